// [core/apd_consts.svh]
`ifndef APD_CONSTS_SVH
`define APD_CONSTS_SVH
// ========================================
// power mode register layout
`define APD_PMR_RESET      8'h00
`define APD_PMR_FIRST_MASK 8'h3A
`define APD_PMR_SECOND_MASK 8'h7C
`define APD_BIT_ENABLE     1
`define APD_BIT_TURBO_OFF  3
`define APD_BIT_ARRAY_CLK  4
`define APD_BIT_MCELL_CLK  5
`define APD_BIT_CNTL_LO    2
`define APD_BIT_CNTL_HI    4
`define APD_BIT_ALE        5
`define APD_BIT_DBE        6
// ========================================
// inactivity counter
`define APD_CNT_ZERO       4'h0
`define APD_CNT_ONE        4'h1
`define APD_CNT_TERM       4'hF
`define APD_CNT_LAST       4'hE
// ========================================
// bus widths and reset levels
`define APD_ADDR_ZERO      16'h0000
`define APD_BYTE_ZERO      8'h00
`define APD_SEL_ZERO       3'h0
`define APD_SEL_IDLE       3'h7
`endif

// [core/apd_pkg.sv]
`include "apd_consts.svh"
package apd_pkg;
  // ========================================
  // inactivity watcher states
  typedef enum logic [1:0] {
    APD_ST_OFF   = 2'b00,  // unit disabled, counter held at zero
    APD_ST_WATCH = 2'b01,  // enabled, counting quiet clock periods
    APD_ST_DOWN  = 2'b10   // power-down mode
  } apd_state_e;
  typedef logic [3:0] apd_count_t;  // four-bit inactivity count
endpackage

// [core/apd_cnt_if.sv]
`timescale 1ns/1ps
interface apd_cnt_if;
  logic       enable;    // automatic power down enabled
  logic       tick;      // one-cycle pulse per pld clock rising edge
  logic       quiet;     // strobe sits at its power-down level
  logic       activity;  // one-cycle pulse per strobe transition
  logic       wake;      // one-cycle pulse: chip select low or reset released
  logic       down;      // power-down flag
  logic [3:0] count;     // current inactivity count
  modport ctl (output enable, tick, quiet, activity, wake, input down, count);
  modport cnt (input enable, tick, quiet, activity, wake, output down, count);
endinterface

// [core/apd_counter.sv]
`timescale 1ns/1ps
`include "apd_consts.svh"
module apd_counter
  import apd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  apd_cnt_if.cnt   cif
);
  // ========================================
  // state and count
  apd_state_e state;       // watcher state
  apd_state_e next_state;  // next watcher state
  apd_count_t count;       // quiet periods seen

  assign cif.down  = (state == APD_ST_DOWN);
  assign cif.count = count;

  // next state: activity, wake or disable leave power-down
  always_comb begin
    next_state = state;
    case (state)
      APD_ST_OFF: begin
        if (cif.enable) next_state = APD_ST_WATCH;
      end
      APD_ST_WATCH: begin
        if (!cif.enable) begin
          next_state = APD_ST_OFF;
        end else if (cif.tick && cif.quiet && !cif.activity && count == `APD_CNT_LAST) begin
          next_state = APD_ST_DOWN;
        end
      end
      APD_ST_DOWN: begin
        if (!cif.enable) begin
          next_state = APD_ST_OFF;
        end else if (cif.activity || cif.wake) begin
          next_state = APD_ST_WATCH;
        end
      end
      default: next_state = APD_ST_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) state <= APD_ST_OFF;
    else         state <= next_state;
  end

  // four-bit counter, counts only on quiet pld clock periods
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= `APD_CNT_ZERO;
    end else if (!cif.enable || cif.activity || cif.wake) begin
      count <= `APD_CNT_ZERO;
    end else if (cif.tick && cif.quiet && count != `APD_CNT_TERM) begin
      count <= count + `APD_CNT_ONE;
    end
  end

  // ========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_down_on_fifteen;
    (state == APD_ST_WATCH) && cif.enable && cif.tick && cif.quiet && !cif.activity
      && count == `APD_CNT_LAST |=> cif.down;
  endproperty
  a_down_on_fifteen: assert property (p_down_on_fifteen) else $error("no power-down at 15");

  property p_no_early_down;
    $rose(cif.down) |-> $past(count) == `APD_CNT_LAST;
  endproperty
  a_no_early_down: assert property (p_no_early_down) else $error("power-down too early");

  property p_activity_clears;
    cif.activity && cif.enable |=> count == `APD_CNT_ZERO && !cif.down;
  endproperty
  a_activity_clears: assert property (p_activity_clears) else $error("activity not cleared");

  property p_disabled_idle;
    !cif.enable |=> count == `APD_CNT_ZERO && !cif.down;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counting while disabled");

  property p_wake_leaves;
    cif.down && cif.wake |=> !cif.down;
  endproperty
  a_wake_leaves: assert property (p_wake_leaves) else $error("wake ignored");

  property p_hold_no_tick;
    !cif.tick && !cif.activity && !cif.wake && cif.enable |=> $stable(count);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved without tick");

  c_enter_down: cover property ($rose(cif.down));
  c_wake_by_strobe: cover property (cif.down && cif.activity);
  c_wake_by_pin: cover property (cif.down && cif.wake);
endmodule

// [core/apd_top.sv]
`timescale 1ns/1ps
`include "apd_consts.svh"
module apd_top
  import apd_pkg::*;
(
  input  wire logic        clk_sys,              // system clock
  input  wire logic        resetn,               // power-up reset
  input  wire logic        dev_reset_n,          // device reset pin
  input  wire logic        addr_strobe,          // mcu address strobe
  input  wire logic        strobe_pd_polarity,   // strobe level while mcu sleeps
  input  wire logic        pld_clock_in,         // pld clock pin
  input  wire logic        csi_n,                // chip select input
  input  wire logic        pmr_first_wr,         // write first power mode register
  input  wire logic        pmr_second_wr,        // write second power mode register
  input  wire logic [7:0]  pmr_wdata,            // power mode write data
  input  wire logic [15:0] bus_addr,             // mcu address
  input  wire logic [7:0]  bus_data,             // mcu data
  input  wire logic [2:0]  mem_sel_req,          // flash, eeprom, sram decode
  input  wire logic        io_sel_req,           // io register window decode
  input  wire logic [2:0]  mcu_cntl,             // mcu control strobes
  input  wire logic        mcu_dbe,              // mcu data byte enable
  input  wire logic [7:0]  pin_out_req,          // port a output value
  input  wire logic [7:0]  pin_oe_req,           // port a output enable
  input  wire logic [7:0]  pin_data_mode,        // pin in data port mode
  input  wire logic [7:0]  pin_periph_mode,      // pin in peripheral mode
  input  wire logic [7:0]  pin_addr_mode,        // pin in address out mode
  output logic [7:0]       power_mode_reg_first, // first power mode register
  output logic [7:0]       power_mode_reg_second,// second power mode register
  output logic             power_down_flag,      // power-down mode active
  output logic [3:0]       apd_count,            // inactivity count
  output logic [15:0]      mem_addr,             // address to memories
  output logic [7:0]       mem_data,             // data to memories
  output logic [2:0]       mem_sel,              // memory selects
  output logic [2:0]       mem_standby,          // memory standby state
  output logic             io_register_window,   // io window select
  output logic [15:0]      pld_addr,             // address to plds
  output logic [2:0]       pld_cntl,             // gated control strobes
  output logic             pld_ale,              // gated address strobe
  output logic             pld_dbe,              // gated byte enable
  output logic             pld_clk_array,        // clock to pld array
  output logic             pld_clk_mcell,        // clock to output cells
  output logic             pld_turbo,            // pld fast mode
  output logic [7:0]       pin_out,              // port a pin value
  output logic [7:0]       pin_oe                // port a pin enable
);
  // ========================================
  // power mode registers
  // cleared only by power-up reset; the device reset pin leaves them alone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_mode_reg_first  <= `APD_PMR_RESET;
      power_mode_reg_second <= `APD_PMR_RESET;
    end else begin
      if (pmr_first_wr)  power_mode_reg_first  <= pmr_wdata & `APD_PMR_FIRST_MASK;
      if (pmr_second_wr) power_mode_reg_second <= pmr_wdata & `APD_PMR_SECOND_MASK;
    end
  end

  // ========================================
  // input conditioning
  logic as_s1;   // strobe synchroniser stage one
  logic as_s2;   // strobe synchroniser stage two
  logic as_s3;   // strobe delayed for edge detect
  logic ck_d;    // pld clock delayed
  logic csi_d;   // chip select delayed
  logic rst_d;   // reset pin delayed

  // two-flop strobe synchroniser then one more stage for edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      as_s1 <= 1'b0;
      as_s2 <= 1'b0;
      as_s3 <= 1'b0;
    end else begin
      as_s1 <= addr_strobe;
      as_s2 <= as_s1;
      as_s3 <= as_s2;
    end
  end

  // delayed copies for edge detection of pins
  // reset to the pins' idle levels so no false tick or wake follows reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ck_d  <= 1'b1;  // clock pin high at release gives no tick
      csi_d <= 1'b0;  // selected is the idle level
      rst_d <= 1'b1;  // reset pin idles high
    end else begin
      ck_d  <= pld_clock_in;
      csi_d <= csi_n;
      rst_d <= dev_reset_n;
    end
  end

  // ========================================
  // inactivity counter
  apd_cnt_if cif ();
  // counter tick taken from the raw pin, before any blocking bit
  assign cif.tick     = pld_clock_in & ~ck_d;
  assign cif.enable   = power_mode_reg_first[`APD_BIT_ENABLE];
  assign cif.activity = as_s2 ^ as_s3;
  assign cif.quiet    = (as_s2 == strobe_pd_polarity);
  assign cif.wake     = (~csi_n & csi_d) | (dev_reset_n & ~rst_d);

  apd_counter apd_counter_i (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cif     (cif)
  );

  logic in_down;  // power-down mode
  assign in_down         = cif.down;
  assign power_down_flag = in_down;
  assign apd_count       = cif.count;

  // ========================================
  // bus blocking and memory selection
  logic addr_moved;  // memory inputs changed this cycle

  // bus to memories and plds frozen while powered down
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_addr <= `APD_ADDR_ZERO;
      mem_data <= `APD_BYTE_ZERO;
      pld_addr <= `APD_ADDR_ZERO;
    end else if (!in_down) begin
      mem_addr <= bus_addr;
      mem_data <= bus_data;
      pld_addr <= bus_addr;
    end
  end

  assign addr_moved = !in_down && (bus_addr != mem_addr || bus_data != mem_data);

  // selects drop in power-down or with chip select high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_sel            <= `APD_SEL_ZERO;
      io_register_window <= 1'b0;
    end else if (in_down || csi_n) begin
      mem_sel            <= `APD_SEL_ZERO;
      io_register_window <= 1'b0;
    end else begin
      mem_sel            <= mem_sel_req;
      io_register_window <= io_sel_req;
    end
  end

  // memories wake only while selected and their inputs move
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_standby <= `APD_SEL_IDLE;
    end else if (in_down || csi_n || !addr_moved) begin
      mem_standby <= `APD_SEL_IDLE;
    end else begin
      mem_standby <= ~mem_sel_req;
    end
  end

  // ========================================
  // pld input blocking, independent of power-down
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pld_cntl      <= `APD_SEL_ZERO;
      pld_ale       <= 1'b0;
      pld_dbe       <= 1'b0;
      pld_clk_array <= 1'b0;
      pld_clk_mcell <= 1'b0;
      pld_turbo     <= 1'b1;
    end else begin
      pld_cntl      <= mcu_cntl
                       & ~power_mode_reg_second[`APD_BIT_CNTL_HI:`APD_BIT_CNTL_LO];
      pld_ale       <= addr_strobe & ~power_mode_reg_second[`APD_BIT_ALE];
      pld_dbe       <= mcu_dbe & ~power_mode_reg_second[`APD_BIT_DBE];
      pld_clk_array <= pld_clock_in & ~power_mode_reg_first[`APD_BIT_ARRAY_CLK];
      pld_clk_mcell <= pld_clock_in & ~power_mode_reg_first[`APD_BIT_MCELL_CLK];
      pld_turbo     <= ~power_mode_reg_first[`APD_BIT_TURBO_OFF];
    end
  end

  // ========================================
  // port pins during power-down
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      // io and pld pins pass through; address holds; data and peripheral pins float
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi]  <= 1'b0;
        end else if (in_down && (pin_data_mode[gi] || pin_periph_mode[gi])) begin
          pin_out[gi] <= pin_out_req[gi];
          pin_oe[gi]  <= 1'b0;
        end else if (in_down && pin_addr_mode[gi]) begin
          pin_oe[gi]  <= pin_oe_req[gi];
        end else begin
          pin_out[gi] <= pin_out_req[gi];
          pin_oe[gi]  <= pin_oe_req[gi];
        end
      end
    end
  endgenerate

  // ========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_block_bus;
    in_down ##1 in_down |-> $stable(mem_addr) && $stable(pld_addr);
  endproperty
  a_block_bus: assert property (p_block_bus) else $error("bus passed in power-down");

  property p_deselect;
    in_down |=> mem_sel == `APD_SEL_ZERO && !io_register_window;
  endproperty
  a_deselect: assert property (p_deselect) else $error("memory selected in power-down");

  property p_csi_standby;
    csi_n |=> mem_standby == `APD_SEL_IDLE && mem_sel == `APD_SEL_ZERO;
  endproperty
  a_csi_standby: assert property (p_csi_standby) else $error("chip select high not standby");

  property p_data_float;
    in_down && pin_data_mode[0] |=> !pin_oe[0];
  endproperty
  a_data_float: assert property (p_data_float) else $error("data pin driven");

  property p_ale_block;
    power_mode_reg_second[`APD_BIT_ALE] |=> !pld_ale;
  endproperty
  a_ale_block: assert property (p_ale_block) else $error("blocked strobe reached pld");

  property p_turbo;
    pld_turbo == !$past(power_mode_reg_first[`APD_BIT_TURBO_OFF]);
  endproperty
  a_turbo: assert property (p_turbo) else $error("fast mode wrong");

  property p_enable_bit;
    !power_mode_reg_first[`APD_BIT_ENABLE] |=> !power_down_flag;
  endproperty
  a_enable_bit: assert property (p_enable_bit) else $error("power-down while disabled");

  property p_regs_keep;
    !pmr_first_wr && !pmr_second_wr |=> $stable(power_mode_reg_first)
      && $stable(power_mode_reg_second);
  endproperty
  a_regs_keep: assert property (p_regs_keep) else $error("power mode register changed");

  c_pin_wake: cover property (in_down ##1 !in_down && !csi_n);
  c_block_clk: cover property (power_mode_reg_first[`APD_BIT_ARRAY_CLK] ##1 in_down);
endmodule

// [verification/apd_mcu_model.sv]
`timescale 1ns/1ps
// ========================================
// host mcu model: address strobe and address/data bus
module apd_mcu_model (
  input  wire logic        clk_sys,     // system clock
  input  wire logic        resetn,      // power-up reset
  input  wire logic        sleep,       // mcu asleep, strobe parked
  input  wire logic        noise,       // foreign bus traffic while asleep
  input  wire logic        pol,         // level the strobe parks at
  output logic             addr_strobe, // address strobe
  output logic [15:0]      bus_addr,    // address bus
  output logic [7:0]       bus_data     // data bus
);
  logic [1:0] phase;    // strobe pulse phase
  logic       sleep_q;  // sleep sampled on the rising edge
  logic       noise_q;  // noise sampled on the rising edge
  logic       pol_q;    // parking level sampled on the rising edge

  // the bench changes these on the falling edge; sample them between falling edges
  always @(posedge clk_sys) begin
    sleep_q <= sleep;
    noise_q <= noise;
    pol_q   <= pol;
  end

  // known levels before the first edge
  initial begin
    phase       = 2'h0;
    addr_strobe = 1'b0;
    bus_addr    = 16'h0000;
    bus_data    = 8'h00;
  end

  // drive after the falling edge so the design samples settled levels
  always @(negedge clk_sys) begin
    if (!resetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
    if (!sleep_q) begin
      // awake: strobe pulses, bus walks every cycle
      addr_strobe <= phase[1];
      bus_addr    <= bus_addr + 16'h0001;
      bus_data    <= ~bus_data;
    end else if (noise_q) begin
      // asleep, other devices still toggle the bus
      addr_strobe <= pol_q;
      bus_addr    <= bus_addr ^ 16'hFFFF;
      bus_data    <= bus_data + 8'h01;
    end else begin
      // asleep, bus parked at known values
      addr_strobe <= pol_q;
      bus_addr    <= 16'h5A00;
      bus_data    <= 8'hC3;
    end
  end
endmodule

// [verification/apd_top_tb.sv]
`timescale 1ns/1ps
// ========================================
// bench for the automatic power down block
module apd_top_tb;
  import apd_pkg::*;
  logic        clk_sys, resetn, dev_reset_n, strobe_pd_polarity, pld_clock_in, csi_n;
  logic        pmr_first_wr, pmr_second_wr, io_sel_req, mcu_dbe, sleep, noise;
  logic        addr_strobe, power_down_flag, io_register_window, pld_ale, pld_dbe;
  logic        pld_clk_array, pld_clk_mcell, pld_turbo;
  logic [15:0] bus_addr, mem_addr, pld_addr;
  logic [7:0]  bus_data, pmr_wdata, pin_out_req, pin_oe_req, pin_data_mode, pin_periph_mode;
  logic [7:0]  pin_addr_mode, power_mode_reg_first, power_mode_reg_second, mem_data;
  logic [7:0]  pin_out, pin_oe;
  logic [3:0]  apd_count;
  logic [2:0]  mem_sel_req, mcu_cntl, mem_sel, mem_standby, pld_cntl;
  int          mismatches, comparisons, cycles;

  // ========================================
  // design and host model
  apd_top apd_top_i (.clk_sys(clk_sys), .resetn(resetn), .dev_reset_n(dev_reset_n),
    .addr_strobe(addr_strobe), .strobe_pd_polarity(strobe_pd_polarity),
    .pld_clock_in(pld_clock_in), .csi_n(csi_n), .pmr_first_wr(pmr_first_wr),
    .pmr_second_wr(pmr_second_wr), .pmr_wdata(pmr_wdata), .bus_addr(bus_addr),
    .bus_data(bus_data), .mem_sel_req(mem_sel_req), .io_sel_req(io_sel_req),
    .mcu_cntl(mcu_cntl), .mcu_dbe(mcu_dbe), .pin_out_req(pin_out_req),
    .pin_oe_req(pin_oe_req), .pin_data_mode(pin_data_mode),
    .pin_periph_mode(pin_periph_mode), .pin_addr_mode(pin_addr_mode),
    .power_mode_reg_first(power_mode_reg_first), .power_mode_reg_second(power_mode_reg_second),
    .power_down_flag(power_down_flag), .apd_count(apd_count), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_sel(mem_sel), .mem_standby(mem_standby),
    .io_register_window(io_register_window), .pld_addr(pld_addr), .pld_cntl(pld_cntl),
    .pld_ale(pld_ale), .pld_dbe(pld_dbe), .pld_clk_array(pld_clk_array),
    .pld_clk_mcell(pld_clk_mcell), .pld_turbo(pld_turbo), .pin_out(pin_out), .pin_oe(pin_oe));

  apd_mcu_model apd_mcu_model_i (.clk_sys(clk_sys), .resetn(resetn), .sleep(sleep),
    .noise(noise), .pol(strobe_pd_polarity), .addr_strobe(addr_strobe),
    .bus_addr(bus_addr), .bus_data(bus_data));

  // ========================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // cut a hang short well past the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ========================================
  // access tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // compare one value, count it and report a difference
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one-cycle write strobe into a power mode register
  task automatic wr(input logic first, input logic [7:0] data);
    @(negedge clk_sys);
    pmr_first_wr  = first;
    pmr_second_wr = !first;
    pmr_wdata     = data;
    @(negedge clk_sys);
    pmr_first_wr  = 1'b0;
    pmr_second_wr = 1'b0;
  endtask

  // n rising edges on the pld clock pin, each level held two cycles
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      pld_clock_in = 1'b1;
      cyc(2);
      pld_clock_in = 1'b0;
      cyc(1);
    end
    cyc(2);
  endtask

  // bounded wait for the flag to reach a level
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 10 && power_down_flag !== v; i++) cyc(1);
    chk("power_down_flag", 16'(v), 16'(power_down_flag));
  endtask

  // park the strobe at pol and run the counter to power-down
  task automatic enter_pd(input logic pol);
    @(negedge clk_sys);
    strobe_pd_polarity = pol;
    sleep              = 1'b1;
    cyc(6);
    tick(14);
    chk("apd_count", 16'h000E, 16'(apd_count));
    chk("power_down_flag", 16'h0000, 16'(power_down_flag));
    tick(1);
    chk("power_down_flag", 16'h0001, 16'(power_down_flag));
    chk("apd_count", 16'h000F, 16'(apd_count));
  endtask

  // ========================================
  // main sequence
  initial begin
    {resetn, dev_reset_n, strobe_pd_polarity, pld_clock_in, csi_n} = 5'b01010;
    {pmr_first_wr, pmr_second_wr, io_sel_req, mcu_dbe, sleep, noise} = 6'b001100;
    pmr_wdata = 8'h00;
    mem_sel_req = 3'h5;
    mcu_cntl = 3'h5;
    pin_out_req = 8'hA5;
    pin_oe_req = 8'hFF;
    pin_data_mode = 8'h03;
    pin_periph_mode = 8'h0C;
    pin_addr_mode = 8'h30;
    cyc(2);
    resetn = 1'b1;
    cyc(2);
    // reset values and normal bus path
    chk("power_mode_reg_first", 16'h0000, 16'(power_mode_reg_first));
    chk("power_mode_reg_second", 16'h0000, 16'(power_mode_reg_second));
    chk("pld_turbo", 16'h0001, 16'(pld_turbo));
    chk("mem_sel", 16'h0005, 16'(mem_sel));
    chk("io_register_window", 16'h0001, 16'(io_register_window));
    chk("mem_standby", 16'h0002, 16'(mem_standby));
    chk("pin_oe", 16'h00FF, 16'(pin_oe));
    // masking and blocking bits at run time, pld clock pin high
    pld_clock_in = 1'b1;
    wr(1'b1, 8'hFF);
    wr(1'b0, 8'hFF);
    cyc(2);
    chk("power_mode_reg_first", 16'h003A, 16'(power_mode_reg_first));
    chk("power_mode_reg_second", 16'h007C, 16'(power_mode_reg_second));
    chk("pld_turbo", 16'h0000, 16'(pld_turbo));
    chk("pld_cntl_ale_dbe", 16'h0000, 16'({pld_cntl, pld_ale, pld_dbe}));
    chk("pld_clk_pair", 16'h0000, 16'({pld_clk_array, pld_clk_mcell}));
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h00);
    cyc(2);
    chk("pld_cntl", 16'h0005, 16'(pld_cntl));
    chk("pld_dbe", 16'h0001, 16'(pld_dbe));
    chk("pld_clk_pair", 16'h0003, 16'({pld_clk_array, pld_clk_mcell}));
    chk("pld_turbo", 16'h0001, 16'(pld_turbo));
    pld_clock_in = 1'b0;
    // disabled unit never counts; static bus leaves memories in standby
    sleep = 1'b1;
    tick(16);
    chk("apd_count", 16'h0000, 16'(apd_count));
    chk("mem_standby", 16'h0007, 16'(mem_standby));
    sleep = 1'b0;
    // pulsing strobe holds the unit out of power-down, pld clocks blocked
    wr(1'b1, 8'h32);
    tick(16);
    chk("power_down_flag", 16'h0000, 16'(power_down_flag));
    // both parking polarities, wake by strobe activity
    for (int p = 0; p < 2; p++) begin
      enter_pd(p[0]);
      sleep = 1'b0;
      wait_flag(1'b0);
      cyc(1);
      chk("apd_count", 16'h0000, 16'(apd_count));
    end
    // power-down effects with noise on the bus
    enter_pd(1'b1);
    noise = 1'b1;
    mem_sel_req = 3'h7;
    mcu_cntl = 3'h3;
    cyc(4);
    chk("mem_addr", 16'h5A00, mem_addr);
    chk("pld_addr", 16'h5A00, pld_addr);
    chk("mem_data", 16'h00C3, 16'(mem_data));
    chk("mem_sel", 16'h0000, 16'({io_register_window, mem_sel}));
    chk("mem_standby", 16'h0007, 16'(mem_standby));
    chk("pld_cntl", 16'h0003, 16'(pld_cntl));
    chk("pld_ale", 16'h0001, 16'(pld_ale));
    chk("pin_oe", 16'h00F0, 16'(pin_oe));
    pin_out_req = 8'h5A;
    cyc(2);
    chk("pin_out", 16'h004A, 16'(pin_out & 8'hCF));
    noise = 1'b0;
    // wake by chip select returning low
    csi_n = 1'b1;
    cyc(2);
    csi_n = 1'b0;
    wait_flag(1'b0);
    chk("apd_count", 16'h0000, 16'(apd_count));
    // wake by device reset rising; registers survive the pulse
    enter_pd(1'b1);
    dev_reset_n = 1'b0;
    cyc(2);
    dev_reset_n = 1'b1;
    wait_flag(1'b0);
    chk("power_mode_reg_first", 16'h0032, 16'(power_mode_reg_first));
    // chip select high deselects memories but leaves plds running
    sleep = 1'b0;
    csi_n = 1'b1;
    cyc(3);
    chk("mem_sel", 16'h0000, 16'({io_register_window, mem_sel}));
    chk("mem_standby", 16'h0007, 16'(mem_standby));
    chk("pld_cntl", 16'h0003, 16'(pld_cntl));
    csi_n = 1'b0;
    cyc(2);
    chk("mem_sel", 16'h0007, 16'(mem_sel));
    // clearing the enable bit leaves power-down
    enter_pd(1'b0);
    wr(1'b1, 8'h00);
    wait_flag(1'b0);
    stop_test();
  end
endmodule
